/* mpgc_pkg.sv */
/*
  Constants and state codes for the module power-good control block.
  Assumes a single 100 MHz clock; no registers reached by software.
*/
`default_nettype none
package mpgc_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 10000;

  // Internal monitor settle time in microseconds
  localparam int unsigned MON_SETTLE_US = 1000;

  // Settle time in clock cycles, rounded up
  localparam int unsigned MON_SETTLE_CYC =
    (MON_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Width of the settle counter
  localparam int unsigned MON_CNT_W = 24;

  // Reset values of the pin drivers
  localparam logic SUPPLY_ON_N_RST = 1'b1;
  localparam logic RESET_OUT_N_RST = 1'b0;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    MPGC_OFF    = 4'h1,
    MPGC_WAIT   = 4'h2,
    MPGC_SETTLE = 4'h4,
    MPGC_RUN    = 4'h8
  } mpgc_state_t;

endpackage
`default_nettype wire

/* mpgc_top.sv */
/*
  Module power-good control: power button toggles the supply request,
  carrier or internal power good gates release of the module reset.
  Assumes carrier inputs are asynchronous to mclk and the button is
  already debounced by the carrier.
*/
// Behaviour
// - High carrier power good permits power sequencing.
// - Module stays in reset while power good low.
// - Without carrier input, internal monitor supplies power good.
// - Supply-on output low means supply on.
// - Debounced button press requests power toggle.
`timescale 1ns/1ps
`default_nettype none
module mpgc_top
  import mpgc_pkg::*;
#(
  // Monitor settle count, shortened in simulation
  parameter int unsigned SETTLE_CYC = mpgc_pkg::MON_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Carrier power-good input and its strap
  input  wire logic carrier_power_good,
  input  wire logic carrier_pg_used,
  // Internal monitor of input voltage and rails
  input  wire logic monitor_good,
  // Power button from carrier
  input  wire logic power_button_request_n,
  // Firmware option: button may also switch off
  input  wire logic button_off_enable,
  // Outputs
  output logic      atx_supply_on_n,
  output logic      module_reset_n,
  output logic      power_on_state
);
  import mpgc_pkg::*;

  // Reset release synchroniser
  logic rst_m_q;
  logic rst_n_q;

  // Input synchronisers, two stages each
  logic pg_m_q;
  logic pg_s_q;
  logic btn_m_q;
  logic btn_s_q;
  logic btn_prev_q;
  logic mon_m_q;
  logic mon_s_q;

  // Sequencer state and settle counter
  mpgc_state_t          state_q;
  mpgc_state_t          state_d;
  logic [MON_CNT_W-1:0] cnt_q;

  // Combined power good and button press pulse
  logic power_good;
  logic press;

  // Settle limit cut to counter width
  localparam logic [MON_CNT_W-1:0] SETTLE_LIM =
    MON_CNT_W'(SETTLE_CYC - 1);

  // Reset released through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // Input synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pg_m_q     <= 1'b0;
      pg_s_q     <= 1'b0;
      btn_m_q    <= 1'b1;
      btn_s_q    <= 1'b1;
      btn_prev_q <= 1'b1;
      mon_m_q    <= 1'b0;
      mon_s_q    <= 1'b0;
    end else begin
      pg_m_q     <= carrier_power_good;
      pg_s_q     <= pg_m_q;
      btn_m_q    <= power_button_request_n;
      btn_s_q    <= btn_m_q;
      btn_prev_q <= btn_s_q;
      mon_m_q    <= monitor_good;
      mon_s_q    <= mon_m_q;
    end
  end

  // Falling edge only, so a held button counts once
  assign press = btn_prev_q & ~btn_s_q;

  // Carrier input when strapped in use, else internal monitor.
  // Internal monitor still gates the carrier path for safety.
  assign power_good = carrier_pg_used ? (pg_s_q & mon_s_q)
                                      : mon_s_q;

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MPGC_OFF: begin
        if (press) begin
          state_d = MPGC_WAIT;
        end
      end
      MPGC_WAIT: begin
        if (press && button_off_enable) begin
          state_d = MPGC_OFF;
        end else if (power_good) begin
          state_d = MPGC_SETTLE;
        end
      end
      MPGC_SETTLE: begin
        if (press && button_off_enable) begin
          state_d = MPGC_OFF;
        end else if (!power_good) begin
          state_d = MPGC_WAIT;
        end else if (cnt_q == SETTLE_LIM) begin
          state_d = MPGC_RUN;
        end
      end
      MPGC_RUN: begin
        if (press && button_off_enable) begin
          state_d = MPGC_OFF;
        end else if (!power_good) begin
          state_d = MPGC_WAIT;
        end
      end
      default: begin
        state_d = MPGC_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= MPGC_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Settle counter; cleared outside the settle state
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= '0;
    end else if (state_q == MPGC_SETTLE) begin
      cnt_q <= cnt_q + MON_CNT_W'(1);
    end else begin
      cnt_q <= '0;
    end
  end

  // Registered pin drivers
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      atx_supply_on_n <= SUPPLY_ON_N_RST;
      module_reset_n  <= RESET_OUT_N_RST;
      power_on_state  <= 1'b0;
    end else begin
      // Low requests main supply outputs
      atx_supply_on_n <= (state_d == MPGC_OFF);
      // Reset released only in run
      module_reset_n  <= (state_d == MPGC_RUN);
      power_on_state  <= (state_d != MPGC_OFF);
    end
  end

  // Assertions
  sequence btn_fall_s;
    btn_prev_q && !btn_s_q;
  endsequence

  sequence off_s;
    state_q == MPGC_OFF;
  endsequence

  reset_pg_low_a: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    !power_good |=> !module_reset_n)
    else $error("Reset released without power good");

  supply_off_a: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    off_s and !press |=> atx_supply_on_n)
    else $error("Supply requested while off");

  press_on_a: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    off_s ##0 btn_fall_s |=> !atx_supply_on_n)
    else $error("Button press did not request supply");

  press_once_a: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    press |=> !press)
    else $error("Button press counted twice");

  // A button still held after switch-off must not switch on again
  held_button_a: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    off_s ##0 !btn_prev_q |=> off_s)
    else $error("Held button acted on again");

  pg_permit_a: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    $rose(module_reset_n) |-> $past(power_good, 2))
    else $error("Run entered without power good");

  monitor_path_a: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    !carrier_pg_used && mon_s_q |-> power_good)
    else $error("Internal monitor not used");

  carrier_gate_a: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    carrier_pg_used && !pg_s_q |-> !power_good)
    else $error("Carrier power good ignored");

  reset_supply_a: assert property (
    @(posedge mclk) disable iff (!rst_n_q)
    module_reset_n |-> !atx_supply_on_n)
    else $error("Running with supply off");

endmodule
`default_nettype wire

/* mpgc_carrier.sv */
/*
  Carrier model: supply enable stage, rail power good, button.
  Assumes mclk comes from the bench; commands come from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module mpgc_carrier #(
  parameter int PG_DLY = 12  // Rail-up delay, shortened
) (
  // Clock and supply request
  input  wire logic mclk,
  input  wire logic atx_supply_on_n,
  // Bench commands
  input  wire logic press,
  input  wire logic pg_hold,
  // Toward the module
  output logic      carrier_power_good,
  output logic      power_button_request_n
);
  int rail_cnt = 0;  // Cycles since supply enabled
  // Standby-powered inverter feeds supply enable
  always @(posedge mclk) begin
    rail_cnt <= !atx_supply_on_n ? rail_cnt + 1 : 0;
  end
  // Low until rails stable, then a delay
  assign carrier_power_good = rail_cnt > PG_DLY && !pg_hold;
  // Debounced active-low momentary button
  assign power_button_request_n = !press;
endmodule
`default_nettype wire

/* testbench.sv */
/*
  Bench for the power-good control block against a carrier model.
  Assumes the settle count is shortened to 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  err_total++; $display("Error %s exp %0b got %0b", n, e, s); end end
module testbench;
  logic mclk = 0, nrst = 0, press = 0, pg_hold = 0;
  logic pg_used = 1, mon = 0, off_en = 1;
  logic carrier_power_good, power_button_request_n;
  logic atx_supply_on_n, module_reset_n, power_on_state;
  int   err_total = 0, checks_done = 0;
  int   exp_on = 0;  // Model: supply requested
  int   n;
  mpgc_top #(.SETTLE_CYC(8)) dut (.mclk(mclk), .nrst(nrst),
    .carrier_power_good(carrier_power_good), .carrier_pg_used(pg_used),
    .monitor_good(mon), .power_button_request_n(power_button_request_n),
    .button_off_enable(off_en), .atx_supply_on_n(atx_supply_on_n),
    .module_reset_n(module_reset_n), .power_on_state(power_on_state));
  mpgc_carrier cb (.mclk(mclk), .atx_supply_on_n(atx_supply_on_n),
    .press(press), .pg_hold(pg_hold),
    .carrier_power_good(carrier_power_good),
    .power_button_request_n(power_button_request_n));
  initial forever #5 mclk = ~mclk;
  task automatic cyc(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // One press; model toggles unless switch-off is barred
  task automatic push(int hold);
    press = 1;
    cyc(hold);
    press = 0;
    cyc(4);
    if (exp_on == 0) exp_on = 1;
    else if (off_en) exp_on = 0;
  endtask
  // Bounded wait for the reset level, then compare all outputs
  task automatic chk();
    logic er;
    er = exp_on != 0 && mon && (!pg_used || carrier_power_good);
    for (n = 0; n < 40 && module_reset_n !== er; n++) cyc(1);
    `CHK("supply_on_n", exp_on == 0, atx_supply_on_n)
    `CHK("on_state", exp_on != 0, power_on_state)
    `CHK("reset_n", er, module_reset_n)
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    conclude();
  end
  initial begin
    void'($urandom(32'hF4BC));
    cyc(5);
    nrst = 1;
    cyc(3);
    chk();
    mon = 1;
    push($urandom_range(1, 8));
    chk();
    cyc(30);
    chk();
    pg_hold = 1;
    cyc(1);
    chk();
    pg_hold = 0;
    cyc(5);
    `CHK("reset_n", 1'b0, module_reset_n)
    cyc(25);
    chk();
    off_en = 0;
    push($urandom_range(1, 8));
    chk();
    off_en = 1;
    push(20);
    cyc(30);
    chk();
    pg_used = 0;
    pg_hold = 1;
    push($urandom_range(1, 8));
    cyc(30);
    chk();
    mon = 0;
    chk();
    push(2);
    chk();
    conclude();
  end
endmodule
`default_nettype wire
